// *** ucf_pkg.sv ***
// Constants, register map and types for the UART channel FIFO block.
// Assumes a single 20 MHz clock domain and an AXI4-Lite register bus.
package ucf_pkg;
   localparam int          DEPTH       = 64;
   localparam int          CNT_W       = 7;
   localparam int          ERR_W       = 2;
   localparam int          FW          = 8 + ERR_W;
   localparam int          ERR_FRAME   = 8;
   localparam int          ERR_BREAK   = 9;
   localparam int          AXI_AW      = 8;
   localparam logic [7:0]  REG_RXDATA  = 8'h00;
   localparam logic [7:0]  REG_TXDATA  = 8'h04;
   localparam logic [7:0]  REG_FCTL    = 8'h08;
   localparam logic [7:0]  REG_LINECTL = 8'h0C;
   localparam logic [7:0]  REG_EFR     = 8'h10;
   localparam logic [7:0]  REG_STATUS  = 8'h14;
   localparam int          FC_EN       = 0;
   localparam int          FC_RXCLR    = 1;
   localparam int          FC_TXCLR    = 2;
   localparam int          FC_DMA      = 3;
   localparam int          FC_TXT      = 4;
   localparam int          FC_RXT      = 6;
   localparam int          EFR_ENH     = 4;
   localparam logic [7:0]  EFR_ENH_MSK = 8'h10;
   localparam int          RD_VALID    = 16;
   localparam int          ST_RXCNT    = 0;
   localparam int          ST_TXCNT    = 8;
   localparam int          ST_RXTRG    = 16;
   localparam int          ST_TXTRG    = 17;
   localparam int          ST_FEN      = 18;
   localparam int          ST_DMA      = 19;
   localparam int          ST_OVR      = 20;
   localparam int          ST_TXBSY    = 21;
   localparam logic [2:0]  WL_MIN_LAST = 3'h4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [15:0] BIT_DIV_DEF = 16'h0010;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
      ucf_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP}
      ucf_tx_state_t;

   function automatic logic [CNT_W-1:0] ucf_rx_level(input logic [1:0] c);
      case (c)
         2'h0:    ucf_rx_level = 7'h08;
         2'h1:    ucf_rx_level = 7'h10;
         2'h2:    ucf_rx_level = 7'h38;
         default: ucf_rx_level = 7'h3C;
      endcase
   endfunction : ucf_rx_level

   function automatic logic [CNT_W-1:0] ucf_tx_level(input logic [1:0] c);
      case (c)
         2'h0:    ucf_tx_level = 7'h08;
         2'h1:    ucf_tx_level = 7'h10;
         2'h2:    ucf_tx_level = 7'h20;
         default: ucf_tx_level = 7'h38;
      endcase
   endfunction : ucf_tx_level
endpackage : ucf_pkg

// *** ucf_fifo.sv ***
// Flip-flop FIFO with clear and a one-entry mode for disabled operation.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
module ucf_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH),
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             clear,
   input  wire logic             oneDeep,
   input  wire logic             overwrite,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] pushData,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   output logic      [CW-1:0]    count,
   output logic                  full,
   output logic                  empty
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [CW-1:0]               count;
   } ucf_fifo_state_t;

   ucf_fifo_state_t st;
   ucf_fifo_state_t next_st;
   logic            doPush;
   logic            doPop;
   logic            grow;

   always_comb begin
      next_st = st;
      full    = oneDeep ? (st.count != '0) : (st.count == CW'(DEPTH));
      empty   = (st.count == '0);
      head    = st.mem[st.rdPtr];
      count   = st.count;
      doPop   = pop && !empty;
      doPush  = push && (!full || doPop || (oneDeep && overwrite));
      grow    = doPush && !(full && !doPop);
      if (doPop) begin
         next_st.rdPtr = oneDeep ? '0 : st.rdPtr + 1'b1;
      end
      if (doPush) begin
         next_st.mem[oneDeep ? '0 : st.wrPtr] = pushData;
         next_st.wrPtr = oneDeep ? '0 : st.wrPtr + 1'b1;
      end
      next_st.count = st.count + CW'(grow) - CW'(doPop);
      if (clear) begin
         next_st.wrPtr = '0;
         next_st.rdPtr = '0;
         next_st.count = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_count_bound: assert property (@(posedge clk) disable iff (!nrst)
      st.count <= CW'(DEPTH)) else $error("FIFO count above depth");
endmodule : ucf_fifo

// *** ucf_channel.sv ***
// UART channel: receive and transmit holding FIFOs, shift registers and
// FIFO control, reached over AXI4-Lite. Assumes one clock and that the
// bus master follows AXI4-Lite handshakes.
`timescale 1ns/1ps
module ucf_channel #(
   parameter logic [15:0] BIT_DIV = ucf_pkg::BIT_DIV_DEF
) (
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic [ucf_pkg::AXI_AW-1:0] awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   input  wire logic [ucf_pkg::AXI_AW-1:0] araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   input  wire logic                      rxd,
   output logic                           txd,
   output logic                           rxTrigger,
   output logic                           txTrigger,
   output logic                           dmaMode
);
   typedef struct packed {
      logic                         awready;
      logic                         wready;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         awHeld;
      logic                         wHeld;
      logic [ucf_pkg::AXI_AW-1:0]   awAddr;
      logic [7:0]                   wData;
      logic                         wStrb0;
      logic                         arready;
      logic                         rvalid;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
      logic                         fifoEn;
      logic                         dmaMode;
      logic [1:0]                   rxTrigCode;
      logic [1:0]                   txTrigCode;
      logic [7:0]                   lineCtl;
      logic [7:0]                   enhanced_feature_reg;
      logic                         rxOverrun;
      logic                         rxTrigger;
      logic                         txTrigger;
      logic                         rxS1;
      logic                         rxS2;
      ucf_pkg::ucf_rx_state_t       rxState;
      logic [15:0]                  rxCnt;
      logic [2:0]                   rxBit;
      logic [7:0]                   rxShift;
      ucf_pkg::ucf_tx_state_t       txState;
      logic [15:0]                  txCnt;
      logic [7:0]                   txShift;
      logic [2:0]                   txBit;
      logic                         txd;
   } ucf_top_state_t;

   ucf_top_state_t                st;
   ucf_top_state_t                next_st;
   logic                          wrFire;
   logic [ucf_pkg::AXI_AW-1:0]    wrAddr;
   logic [7:0]                    wrData;
   logic                          rxPush;
   logic                          rxPop;
   logic                          rxClr;
   logic                          txPush;
   logic                          txPop;
   logic                          txClr;
   logic [ucf_pkg::FW-1:0]        rxChar;
   logic [ucf_pkg::FW-1:0]        rxHead;
   logic [7:0]                    txHead;
   logic [ucf_pkg::CNT_W-1:0]     rxCount;
   logic [ucf_pkg::CNT_W-1:0]     txCount;
   logic                          rxFull;
   logic                          rxEmpty;
   logic                          txFull;
   logic                          txEmpty;
   logic [2:0]                    lastBit;

   // Receive holding FIFO, one-entry overwrite when disabled
   ucf_fifo #(.WIDTH(ucf_pkg::FW), .DEPTH(ucf_pkg::DEPTH)) u_rxFifo (
      .clk       (clk),
      .nrst      (nrst),
      .clear     (rxClr),
      .oneDeep   (!st.fifoEn),
      .overwrite (1'b1),
      .push      (rxPush),
      .pushData  (rxChar),
      .pop       (rxPop),
      .head      (rxHead),
      .count     (rxCount),
      .full      (rxFull),
      .empty     (rxEmpty)
   );

   // Transmit holding FIFO, one entry without overwrite when disabled
   ucf_fifo #(.WIDTH(8), .DEPTH(ucf_pkg::DEPTH)) u_txFifo (
      .clk       (clk),
      .nrst      (nrst),
      .clear     (txClr),
      .oneDeep   (!st.fifoEn),
      .overwrite (1'b0),
      .push      (txPush),
      .pushData  (wrData),
      .pop       (txPop),
      .head      (txHead),
      .count     (txCount),
      .full      (txFull),
      .empty     (txEmpty)
   );

   always_comb begin
      next_st = st;
      rxPush  = 1'b0;
      rxPop   = 1'b0;
      rxClr   = 1'b0;
      txPush  = 1'b0;
      txPop   = 1'b0;
      txClr   = 1'b0;
      rxChar  = '0;
      lastBit = ucf_pkg::WL_MIN_LAST + {1'b0, st.lineCtl[1:0]};

      // Write address and data are taken independently
      if (awvalid && st.awready) begin
         next_st.awHeld = 1'b1;
         next_st.awAddr = awaddr;
      end
      if (wvalid && st.wready) begin
         next_st.wHeld  = 1'b1;
         next_st.wData  = wdata[7:0];
         next_st.wStrb0 = wstrb[0];
      end
      if (st.bvalid && bready) begin
         next_st.bvalid = 1'b0;
      end
      wrFire = next_st.awHeld && next_st.wHeld && next_st.wStrb0;
      wrAddr = next_st.awAddr;
      wrData = next_st.wData;
      if (next_st.awHeld && next_st.wHeld) begin
         next_st.awHeld = 1'b0;
         next_st.wHeld  = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp  = ucf_pkg::RESP_OKAY;
         if (wrAddr == ucf_pkg::REG_TXDATA) begin
            txPush = wrFire;
         end else if (wrAddr == ucf_pkg::REG_FCTL) begin
            if (wrFire) begin
               next_st.fifoEn  = wrData[ucf_pkg::FC_EN];
               next_st.dmaMode = wrData[ucf_pkg::FC_DMA];
               next_st.rxTrigCode = wrData[ucf_pkg::FC_RXT +: 2];
               if (st.enhanced_feature_reg[ucf_pkg::EFR_ENH]) begin
                  next_st.txTrigCode = wrData[ucf_pkg::FC_TXT +: 2];
               end
               rxClr = wrData[ucf_pkg::FC_RXCLR] ||
                       (wrData[ucf_pkg::FC_EN] != st.fifoEn);
               txClr = wrData[ucf_pkg::FC_TXCLR] ||
                       (wrData[ucf_pkg::FC_EN] != st.fifoEn);
            end
         end else if (wrAddr == ucf_pkg::REG_LINECTL) begin
            if (wrFire) begin
               next_st.lineCtl = wrData;
            end
         end else if (wrAddr == ucf_pkg::REG_EFR) begin
            if (wrFire) begin
               next_st.enhanced_feature_reg = st.enhanced_feature_reg[ucf_pkg::EFR_ENH] ? wrData :
                  (st.enhanced_feature_reg & ~ucf_pkg::EFR_ENH_MSK) |
                  (wrData & ucf_pkg::EFR_ENH_MSK);
            end
         end else if (wrAddr != ucf_pkg::REG_RXDATA &&
                      wrAddr != ucf_pkg::REG_STATUS) begin
            next_st.bresp = ucf_pkg::RESP_SLVERR;
         end
      end
      next_st.awready = !next_st.awHeld && !next_st.bvalid;
      next_st.wready  = !next_st.wHeld && !next_st.bvalid;

      // Read channel; reading the data register pops the receive FIFO
      if (st.rvalid && rready) begin
         next_st.rvalid = 1'b0;
      end
      if (arvalid && st.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rresp  = ucf_pkg::RESP_OKAY;
         next_st.rdata  = '0;
         if (araddr == ucf_pkg::REG_RXDATA) begin
            next_st.rdata[ucf_pkg::FW-1:0]     = rxHead;
            next_st.rdata[ucf_pkg::RD_VALID]   = !rxEmpty;
            rxPop = 1'b1;
         end else if (araddr == ucf_pkg::REG_STATUS) begin
            next_st.rdata[ucf_pkg::ST_RXCNT +: ucf_pkg::CNT_W] = rxCount;
            next_st.rdata[ucf_pkg::ST_TXCNT +: ucf_pkg::CNT_W] = txCount;
            next_st.rdata[ucf_pkg::ST_RXTRG] = st.rxTrigger;
            next_st.rdata[ucf_pkg::ST_TXTRG] = st.txTrigger;
            next_st.rdata[ucf_pkg::ST_FEN]   = st.fifoEn;
            next_st.rdata[ucf_pkg::ST_DMA]   = st.dmaMode;
            next_st.rdata[ucf_pkg::ST_OVR]   = st.rxOverrun;
            next_st.rdata[ucf_pkg::ST_TXBSY] = st.txState != ucf_pkg::TX_IDLE;
            next_st.rxOverrun = 1'b0;
         end else if (araddr == ucf_pkg::REG_LINECTL) begin
            next_st.rdata[7:0] = st.lineCtl;
         end else if (araddr == ucf_pkg::REG_EFR) begin
            next_st.rdata[7:0] = st.enhanced_feature_reg;
         end else if (araddr != ucf_pkg::REG_FCTL &&
                      araddr != ucf_pkg::REG_TXDATA) begin
            next_st.rresp = ucf_pkg::RESP_SLVERR;
         end
      end
      next_st.arready = !next_st.rvalid;

      // Receive shifter, sampled mid-bit
      next_st.rxS1 = rxd;
      next_st.rxS2 = st.rxS1;
      next_st.rxCnt = st.rxCnt - 16'h0001;
      case (st.rxState)
         ucf_pkg::RX_IDLE: begin
            next_st.rxCnt = BIT_DIV >> 1;
            if (!st.rxS2) begin
               next_st.rxState = ucf_pkg::RX_START;
            end
         end
         ucf_pkg::RX_START: begin
            if (st.rxCnt == '0) begin
               next_st.rxCnt   = BIT_DIV - 16'h0001;
               next_st.rxBit   = '0;
               next_st.rxShift = '0;
               next_st.rxState = st.rxS2 ? ucf_pkg::RX_IDLE :
                                           ucf_pkg::RX_DATA;
            end
         end
         ucf_pkg::RX_DATA: begin
            if (st.rxCnt == '0) begin
               next_st.rxCnt = BIT_DIV - 16'h0001;
               next_st.rxShift[st.rxBit] = st.rxS2;
               next_st.rxBit = st.rxBit + 3'h1;
               if (st.rxBit == lastBit) begin
                  next_st.rxState = ucf_pkg::RX_STOP;
               end
            end
         end
         default: begin
            if (st.rxCnt == '0) begin
               rxPush = 1'b1;
               rxChar[7:0] = st.rxShift;
               rxChar[ucf_pkg::ERR_FRAME] = !st.rxS2;
               rxChar[ucf_pkg::ERR_BREAK] = !st.rxS2 && (st.rxShift == '0);
               next_st.rxState = ucf_pkg::RX_IDLE;
            end
         end
      endcase
      // Overrun set wins over the clear-on-read above
      if (rxPush && rxFull && !(rxPop && !rxEmpty)) begin
         next_st.rxOverrun = 1'b1;
      end

      // Transmit shifter
      next_st.txCnt = st.txCnt - 16'h0001;
      case (st.txState)
         ucf_pkg::TX_IDLE: begin
            next_st.txd = 1'b1;
            if (!txEmpty) begin
               txPop = 1'b1;
               next_st.txShift = txHead;
               next_st.txCnt   = BIT_DIV - 16'h0001;
               next_st.txd     = 1'b0;
               next_st.txState = ucf_pkg::TX_START;
            end
         end
         ucf_pkg::TX_START: begin
            if (st.txCnt == '0) begin
               next_st.txCnt   = BIT_DIV - 16'h0001;
               next_st.txBit   = '0;
               next_st.txd     = st.txShift[0];
               next_st.txState = ucf_pkg::TX_DATA;
            end
         end
         ucf_pkg::TX_DATA: begin
            if (st.txCnt == '0) begin
               next_st.txCnt   = BIT_DIV - 16'h0001;
               next_st.txShift = {1'b0, st.txShift[7:1]};
               next_st.txBit   = st.txBit + 3'h1;
               next_st.txd     = st.txShift[1];
               if (st.txBit == lastBit) begin
                  next_st.txd     = 1'b1;
                  next_st.txState = ucf_pkg::TX_STOP;
               end
            end
         end
         default: begin
            if (st.txCnt == '0) begin
               next_st.txState = ucf_pkg::TX_IDLE;
            end
         end
      endcase

      next_st.rxTrigger = rxCount >=
         ucf_pkg::ucf_rx_level(st.rxTrigCode);
      next_st.txTrigger = st.enhanced_feature_reg[ucf_pkg::EFR_ENH] &&
         (ucf_pkg::CNT_W'(ucf_pkg::DEPTH) - txCount >=
          ucf_pkg::ucf_tx_level(st.txTrigCode));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st      <= '0;
         st.txd  <= 1'b1;
         st.rxS1 <= 1'b1;
         st.rxS2 <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign awready   = st.awready;
   assign wready    = st.wready;
   assign bvalid    = st.bvalid;
   assign bresp     = st.bresp;
   assign arready   = st.arready;
   assign rvalid    = st.rvalid;
   assign rresp     = st.rresp;
   assign rdata     = st.rdata;
   assign txd       = st.txd;
   assign rxTrigger = st.rxTrigger;
   assign txTrigger = st.txTrigger;
   assign dmaMode   = st.dmaMode;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_tx_clear_empty: assert property (
      txClr |=> txCount == '0) else $error("TX FIFO not emptied");
   a_rx_clear_empty: assert property (
      rxClr && !rxPush |=> rxCount == '0) else $error("RX FIFO not emptied");
   a_rx_one_entry: assert property (
      !st.fifoEn && $past(!st.fifoEn) |-> rxCount <= 7'h01)
      else $error("Disabled RX FIFO holds more than one");
   a_rx_full_drop: assert property (
      st.fifoEn && rxFull && rxPush && !rxPop && !rxClr |=> rxFull &&
      rxCount == $past(rxCount)) else $error("Full RX FIFO grew");
   a_tx_trig_gate: assert property (
      !st.enhanced_feature_reg[ucf_pkg::EFR_ENH] |=> !txTrigger)
      else $error("TX trigger without enhanced enable");
   a_rx_trig_level: assert property (
      rxTrigger == $past(rxCount >= ucf_pkg::ucf_rx_level(st.rxTrigCode)))
      else $error("RX trigger does not follow level");
   a_fctl_reads_zero: assert property (
      arvalid && arready && araddr == ucf_pkg::REG_FCTL |=>
      rvalid && rdata == 32'h0000_0000) else $error("Control read not zero");
   a_dma_mode_set: assert property (
      wrFire && wrAddr == ucf_pkg::REG_FCTL |=>
      dmaMode == $past(wrData[ucf_pkg::FC_DMA])) else $error("DMA mode wrong");
   a_fifo_enable: assert property (
      wrFire && wrAddr == ucf_pkg::REG_FCTL |=>
      st.fifoEn == $past(wrData[ucf_pkg::FC_EN])) else $error("Enable wrong");
   a_tx_load_idle: assert property (
      txPop |-> st.txState == ucf_pkg::TX_IDLE && !txEmpty ##1
      st.txState == ucf_pkg::TX_START && !txd) else $error("Bad TX load");

   c_rx_char: cover property (rxPush && st.fifoEn);
   c_rx_full: cover property (rxFull && st.fifoEn && rxPush);
   c_tx_send: cover property (st.txState == ucf_pkg::TX_STOP);
   c_fifo_clr: cover property (rxClr && txClr);
endmodule : ucf_channel

// *** ucf_serial_src.sv ***
// Serial source on the receive line and sampler of the transmit line.
// Assumes frames start just after a clock edge; lines idle high.
`timescale 1ns/1ps
module ucf_serial_src #(parameter int DIV = 4) (
   input  wire logic clk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;
   task automatic send(input logic [7:0] c, input int nb, input logic stp);
      rxd <= 1'b0;
      repeat (DIV) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         rxd <= c[i];
         repeat (DIV) @(posedge clk);
      end
      rxd <= stp;
      repeat (DIV) @(posedge clk);
      rxd <= 1'b1;
      repeat (2 * DIV) @(posedge clk);
   endtask : send
   // Bits land in c[nb-1:0], the stop level in c[8]
   task automatic take_char(output logic [8:0] c, input int nb);
      c = 9'h000;
      while (txd !== 1'b0) @(posedge clk);
      repeat (DIV / 2) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         repeat (DIV) @(posedge clk);
         c[i] = txd;
      end
      repeat (DIV) @(posedge clk);
      c[8] = txd;
   endtask : take_char
endmodule : ucf_serial_src

// *** ucf_channel_tb.sv ***
// Testbench for the UART channel FIFO block over AXI4-Lite.
// Assumes the serial source model drives the receive line.
`timescale 1ns/1ps
module ucf_channel_tb;
   logic        clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        rxd, txd, rxTrigger, txTrigger, dmaMode;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rsp;
   logic [8:0]  ch;
   int          error_cnt = 0, n_compared = 0, cyc = 0;
   ucf_channel #(.BIT_DIV(16'h0004)) ucf_channel_inst (.clk(clk),
      .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd),
      .rxTrigger(rxTrigger), .txTrigger(txTrigger), .dmaMode(dmaMode));
   ucf_serial_src #(.DIV(4)) ucf_serial_src_inst (.clk(clk), .txd(txd),
      .rxd(rxd));
   always #25 clk = ~clk;
   task automatic complete_run;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w, b;
      b = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(negedge clk);
         aw = awready;
         w = wready;
         b = bvalid;
         rsp = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      logic ar, r;
      r = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r) begin
         @(negedge clk);
         ar = arready;
         r = rvalid;
         rd = rdata;
         rsp = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : rdr
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rdr(8'h14);
      chk("status", rd, 32'h0);
      rdr(8'h08);
      chk("fctl", rd, 32'h0);
      rdr(8'hF0);
      chk("rresp", {30'h0, rsp}, 32'h2);
      wr(8'hF0, 8'h00);
      chk("bresp", {30'h0, rsp}, 32'h2);
      ucf_serial_src_inst.send(8'h11, 5, 1'b1);
      ucf_serial_src_inst.send(8'h00, 5, 1'b0);
      rdr(8'h14);
      chk("ovrwr", {24'h0, rd[20], rd[6:0]}, 32'h81);
      rdr(8'h00);
      chk("rxerr", rd, 32'h00010300);
      wr(8'h04, 8'h01);
      wr(8'h04, 8'h02);
      wr(8'h04, 8'h03);
      rdr(8'h14);
      chk("txone", {25'h0, rd[14:8]}, 32'h1);
      wr(8'h08, 8'h09);
      chk("dma", {31'h0, dmaMode}, 32'h1);
      chk("bresp", {30'h0, rsp}, 32'h0);
      for (int i = 1; i <= 8; i++) begin
         ucf_serial_src_inst.send(i[7:0], 5, 1'b1);
         repeat (4) @(posedge clk);
         chk("rxtrg", {31'h0, rxTrigger}, {31'h0, i == 8});
      end
      rdr(8'h00);
      chk("rxdata", rd, 32'h00010001);
      rdr(8'h14);
      chk("rxcnt", {25'h0, rd[6:0]}, 32'h7);
      wr(8'h08, 8'h0B);
      rdr(8'h14);
      chk("rxclr", {25'h0, rd[6:0]}, 32'h0);
      for (int i = 0; i < 65; i++) begin
         ucf_serial_src_inst.send(i[7:0], 5, 1'b1);
      end
      rdr(8'h14);
      chk("rxfull", {24'h0, rd[20], rd[6:0]}, 32'hC0);
      wr(8'h0C, 8'h03);
      wr(8'h04, 8'hA5);
      wr(8'h04, 8'h5A);
      wr(8'h04, 8'h3C);
      rdr(8'h14);
      chk("txcnt", {25'h0, rd[14:8]}, 32'h2);
      wr(8'h08, 8'h0D);
      rdr(8'h14);
      chk("txclr", {24'h0, rd[21], rd[14:8]}, 32'h80);
      wr(8'h08, 8'h39);
      chk("txtrg", {31'h0, txTrigger}, 32'h0);
      wr(8'h10, 8'hFF);
      rdr(8'h10);
      chk("efr", rd, 32'h10);
      wr(8'h10, 8'h13);
      rdr(8'h10);
      chk("efr", rd, 32'h13);
      wr(8'h08, 8'h31);
      repeat (2) @(posedge clk);
      chk("txtrg", {31'h0, txTrigger}, 32'h1);
      chk("dma", {31'h0, dmaMode}, 32'h0);
      repeat (40) @(posedge clk);
      wr(8'h0C, 8'h01);
      wr(8'h04, 8'hED);
      ucf_serial_src_inst.take_char(ch, 6);
      chk("txline", {23'h0, ch}, 32'h12D);
      complete_run();
   end
endmodule : ucf_channel_tb
